// [rtl/dcs_pkg.sv]
`default_nettype none
package dcs_pkg;
	// command codes: {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_MODE_SET = 4'h0;

	typedef enum logic [3:0] {
		DCS_DESELECT = 4'h0,
		DCS_NOP = 4'h1,
		DCS_READ = 4'h2,
		DCS_WRITE = 4'h3,
		DCS_ACTIVATE = 4'h4,
		DCS_PRECHARGE = 4'h5,
		DCS_REFRESH = 4'h6,
		DCS_MODE_SET = 4'h7
	} dcs_cmd_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ACTIVE = 7'h02,
		ST_READ = 7'h04,
		ST_WRITE = 7'h08,
		ST_PRECHARGE_PD = 7'h10,
		ST_ACTIVE_PD = 7'h20,
		ST_SELF_REFRESH = 7'h40
	} dcs_state_t;

	// clock period and self refresh exit periods
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int SELF_REFRESH_EXIT_NONREAD_DELAY_NS = 200;
	localparam int SELF_REFRESH_EXIT_NONREAD_CYCLES =
		(SELF_REFRESH_EXIT_NONREAD_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SELF_REFRESH_EXIT_READ_DELAY_CLOCKS = 200;
	localparam int CLOCK_GATE_MIN_HOLD_CLOCKS = 3;
	localparam int BURST_BEATS = 4;
	localparam int WAIT_WIDTH = 8;
	localparam int BURST_WIDTH = 3;
	localparam int BEAT_WIDTH = 8;
endpackage
`default_nettype wire

// [rtl/dcs_decode.sv]
`default_nettype none
module dcs_decode (
	// command lines, sampled levels
	input wire logic chip_select_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	// decoded command
	output var dcs_pkg::dcs_cmd_t command
);
	function automatic dcs_pkg::dcs_cmd_t decode(input logic [3:0] lines);
		dcs_pkg::dcs_cmd_t c;
		c = dcs_pkg::DCS_DESELECT;
		if (!lines[3]) begin
			case (lines)
				dcs_pkg::CMD_NOP: c = dcs_pkg::DCS_NOP;
				dcs_pkg::CMD_READ: c = dcs_pkg::DCS_READ;
				dcs_pkg::CMD_WRITE: c = dcs_pkg::DCS_WRITE;
				dcs_pkg::CMD_ACTIVATE: c = dcs_pkg::DCS_ACTIVATE;
				dcs_pkg::CMD_PRECHARGE: c = dcs_pkg::DCS_PRECHARGE;
				dcs_pkg::CMD_REFRESH: c = dcs_pkg::DCS_REFRESH;
				dcs_pkg::CMD_MODE_SET: c = dcs_pkg::DCS_MODE_SET;
				default: c = dcs_pkg::DCS_DESELECT;
			endcase
		end
		return c;
	endfunction

	// chip select high overrides the strobes
	assign command = decode({chip_select_n, ras_n, cas_n, we_n});
endmodule
`default_nettype wire

// [rtl/dcs_beat_mask.sv]
`default_nettype none
module dcs_beat_mask (
	input wire logic clock,
	input wire logic resetn,
	input wire logic enable,
	// write beat from the controller
	input wire logic beat_valid,
	input wire logic write_beat_mask,
	input wire logic [7:0] beat_data,
	// stored result
	output logic write_strobe,
	output logic [7:0] write_data
);
	logic next_write_strobe;
	logic [7:0] next_write_data;

	always_comb begin
		next_write_strobe = beat_valid & ~write_beat_mask;
		next_write_data = next_write_strobe ? beat_data : write_data;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			write_strobe <= 1'b0;
			write_data <= 8'h00;
		end else if (enable) begin
			write_strobe <= next_write_strobe;
			write_data <= next_write_data;
		end
	end
endmodule
`default_nettype wire

// [rtl/dcs_top.sv]
`default_nettype none
module dcs_top #(
	parameter int NONREAD_EXIT_CYCLES = dcs_pkg::SELF_REFRESH_EXIT_NONREAD_CYCLES,
	parameter int READ_EXIT_CYCLES = dcs_pkg::SELF_REFRESH_EXIT_READ_DELAY_CLOCKS
) (
	// clock, reset, freeze
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic ENABLE,
	// memory command pins
	input wire logic CLOCK_GATE,
	input wire logic CHIP_SELECT_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic TERMINATION_ENABLE,
	// write data
	input wire logic BEAT_VALID,
	input wire logic WRITE_BEAT_MASK,
	input wire logic [7:0] BEAT_DATA,
	// state and events
	output logic [6:0] STATE,
	output logic ROW_ACTIVATE,
	output logic REFRESH_START,
	output logic MODE_ACCESS,
	output logic BURST_START,
	output logic BURST_DONE,
	output logic TERMINATION_ACTIVE,
	output logic ILLEGAL_COMMAND,
	output logic EXIT_VIOLATION,
	output logic GATE_HOLD_VIOLATION,
	output logic WRITE_STROBE,
	output logic [7:0] WRITE_DATA
);
	dcs_pkg::dcs_cmd_t command;
	dcs_pkg::dcs_state_t state, next_state;
	logic gate_prev, next_gate_prev;
	logic [dcs_pkg::BURST_WIDTH-1:0] burst_left, next_burst_left;
	logic [dcs_pkg::WAIT_WIDTH-1:0] nonread_wait, next_nonread_wait;
	logic [dcs_pkg::WAIT_WIDTH-1:0] read_wait, next_read_wait;
	logic [1:0] hold_count, next_hold_count;
	logic next_row_activate;
	logic next_refresh_start;
	logic next_mode_access;
	logic next_burst_start;
	logic next_burst_done;
	logic next_termination_active;
	logic next_illegal;
	logic next_exit_violation;
	logic next_hold_violation;
	logic gate_rise;
	logic gate_fall;
	logic gate_low;
	logic gate_high;
	logic is_idle_cmd;

	// floors at zero, so a spent counter never wraps
	function automatic logic [dcs_pkg::WAIT_WIDTH-1:0] count_down(
		input logic [dcs_pkg::WAIT_WIDTH-1:0] value
	);
		if (value == '0) begin
			return value;
		end
		return value - 1'b1;
	endfunction

	// a same-direction command restarts the running burst
	function automatic logic same_direction(
		input dcs_pkg::dcs_state_t current,
		input dcs_pkg::dcs_cmd_t cmd
	);
		return (current == dcs_pkg::ST_READ && cmd == dcs_pkg::DCS_READ) ||
			(current == dcs_pkg::ST_WRITE && cmd == dcs_pkg::DCS_WRITE);
	endfunction

	dcs_decode u_decode (
		.chip_select_n(CHIP_SELECT_N),
		.ras_n(RAS_N),
		.cas_n(CAS_N),
		.we_n(WE_N),
		.command(command)
	);

	dcs_beat_mask u_mask (
		.clock(CLOCK),
		.resetn(RESETN),
		.enable(ENABLE),
		.beat_valid(BEAT_VALID),
		.write_beat_mask(WRITE_BEAT_MASK),
		.beat_data(BEAT_DATA),
		.write_strobe(WRITE_STROBE),
		.write_data(WRITE_DATA)
	);

	always_comb begin
		// transition type from the two samples
		gate_rise = !gate_prev && CLOCK_GATE;
		gate_fall = gate_prev && !CLOCK_GATE;
		gate_low = !gate_prev && !CLOCK_GATE;
		gate_high = gate_prev && CLOCK_GATE;
		is_idle_cmd = (command == dcs_pkg::DCS_DESELECT) || (command == dcs_pkg::DCS_NOP);
	end

	always_comb begin
		next_state = state;
		next_gate_prev = CLOCK_GATE;
		next_burst_left = burst_left;
		next_nonread_wait = nonread_wait;
		next_read_wait = read_wait;
		next_row_activate = 1'b0;
		next_refresh_start = 1'b0;
		next_mode_access = 1'b0;
		next_burst_start = 1'b0;
		next_burst_done = 1'b0;
		next_illegal = 1'b0;
		next_exit_violation = 1'b0;
		next_hold_violation = 1'b0;
		next_hold_count = hold_count;
		// gate must be registered on three edges after a change
		if (gate_rise || gate_fall) begin
			if (hold_count != 2'(dcs_pkg::CLOCK_GATE_MIN_HOLD_CLOCKS)) begin
				next_hold_violation = 1'b1;
			end
			// the change edge is the first of the three
			next_hold_count = 2'h1;
		end else if (hold_count != 2'(dcs_pkg::CLOCK_GATE_MIN_HOLD_CLOCKS)) begin
			next_hold_count = hold_count + 2'h1;
		end
		// exit wait counters run down in any state, awake or powered down
		if (nonread_wait != '0) begin
			next_nonread_wait = count_down(nonread_wait);
			if (gate_high && !is_idle_cmd) begin
				next_exit_violation = 1'b1;
			end
		end
		if (read_wait != '0) begin
			next_read_wait = count_down(read_wait);
			if (gate_high && command == dcs_pkg::DCS_READ) begin
				next_exit_violation = 1'b1;
			end
		end
		// burst counter runs out unless interrupted
		if (burst_left != '0) begin
			next_burst_left = burst_left - 1'b1;
		end
		// action from state before the edge and command of this edge
		case (state)
			dcs_pkg::ST_PRECHARGE_PD, dcs_pkg::ST_ACTIVE_PD: begin
				// commands ignored while gate stays low
				if (gate_low) begin
					// no refresh is started while powered down
					next_refresh_start = 1'b0;
					next_state = state;
				end else if (gate_rise) begin
					if (is_idle_cmd) begin
						next_state = (state == dcs_pkg::ST_ACTIVE_PD) ?
							dcs_pkg::ST_ACTIVE : dcs_pkg::ST_IDLE;
					end else begin
						next_illegal = 1'b1;
					end
				end
			end
			dcs_pkg::ST_SELF_REFRESH: begin
				if (gate_rise) begin
					if (is_idle_cmd) begin
						next_state = dcs_pkg::ST_IDLE;
						next_nonread_wait = dcs_pkg::WAIT_WIDTH'(NONREAD_EXIT_CYCLES);
						next_read_wait = dcs_pkg::WAIT_WIDTH'(READ_EXIT_CYCLES);
					end else begin
						next_illegal = 1'b1;
					end
				end
			end
			dcs_pkg::ST_IDLE: begin
				if (gate_fall) begin
					if (is_idle_cmd) begin
						next_state = dcs_pkg::ST_PRECHARGE_PD;
					end else if (command == dcs_pkg::DCS_REFRESH) begin
						next_state = dcs_pkg::ST_SELF_REFRESH;
					end else begin
						next_illegal = 1'b1;
					end
				end else if (gate_high) begin
					// idle actions
					case (command)
						dcs_pkg::DCS_ACTIVATE: begin
							next_row_activate = 1'b1;
							next_state = dcs_pkg::ST_ACTIVE;
						end
						dcs_pkg::DCS_REFRESH: next_refresh_start = 1'b1;
						dcs_pkg::DCS_MODE_SET: next_mode_access = 1'b1;
						dcs_pkg::DCS_READ, dcs_pkg::DCS_WRITE: next_illegal = 1'b1;
						default: next_state = dcs_pkg::ST_IDLE;
					endcase
				end
			end
			dcs_pkg::ST_ACTIVE: begin
				if (gate_fall) begin
					if (is_idle_cmd) begin
						next_state = dcs_pkg::ST_ACTIVE_PD;
					end else begin
						next_illegal = 1'b1;
					end
				end else if (gate_high) begin
					// banks-active actions
					case (command)
						dcs_pkg::DCS_READ, dcs_pkg::DCS_WRITE: begin
							next_burst_start = 1'b1;
							next_burst_left = dcs_pkg::BURST_WIDTH'(dcs_pkg::BURST_BEATS);
							next_state = (command == dcs_pkg::DCS_READ) ?
								dcs_pkg::ST_READ : dcs_pkg::ST_WRITE;
						end
						dcs_pkg::DCS_PRECHARGE: next_state = dcs_pkg::ST_IDLE;
						// other banks not modelled: same-bank activate flagged
						dcs_pkg::DCS_ACTIVATE, dcs_pkg::DCS_REFRESH,
						dcs_pkg::DCS_MODE_SET: next_illegal = 1'b1;
						default: next_state = dcs_pkg::ST_ACTIVE;
					endcase
				end
			end
			dcs_pkg::ST_READ, dcs_pkg::ST_WRITE: begin
				if (!gate_high) begin
					next_illegal = 1'b1;
				end else if (is_idle_cmd) begin
					if (burst_left == dcs_pkg::BURST_WIDTH'(1)) begin
						next_burst_done = 1'b1;
						next_state = dcs_pkg::ST_ACTIVE;
					end
				end else if (same_direction(state, command)) begin
					next_burst_start = 1'b1;
					next_burst_left = dcs_pkg::BURST_WIDTH'(dcs_pkg::BURST_BEATS);
				end else begin
					next_illegal = 1'b1;
				end
			end
			default: next_state = dcs_pkg::ST_IDLE;
		endcase
		// termination off in self refresh; never steers state
		next_termination_active = TERMINATION_ENABLE &&
			(next_state != dcs_pkg::ST_SELF_REFRESH);
	end

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			state <= dcs_pkg::ST_IDLE;
			gate_prev <= 1'b0;
			burst_left <= '0;
			nonread_wait <= '0;
			read_wait <= '0;
			hold_count <= 2'(dcs_pkg::CLOCK_GATE_MIN_HOLD_CLOCKS);
			ROW_ACTIVATE <= 1'b0;
			REFRESH_START <= 1'b0;
			MODE_ACCESS <= 1'b0;
			BURST_START <= 1'b0;
			BURST_DONE <= 1'b0;
			TERMINATION_ACTIVE <= 1'b0;
			ILLEGAL_COMMAND <= 1'b0;
			EXIT_VIOLATION <= 1'b0;
			GATE_HOLD_VIOLATION <= 1'b0;
			STATE <= dcs_pkg::ST_IDLE;
		end else if (ENABLE) begin
			state <= next_state;
			gate_prev <= next_gate_prev;
			burst_left <= next_burst_left;
			nonread_wait <= next_nonread_wait;
			read_wait <= next_read_wait;
			hold_count <= next_hold_count;
			ROW_ACTIVATE <= next_row_activate;
			REFRESH_START <= next_refresh_start;
			MODE_ACCESS <= next_mode_access;
			BURST_START <= next_burst_start;
			BURST_DONE <= next_burst_done;
			TERMINATION_ACTIVE <= next_termination_active;
			ILLEGAL_COMMAND <= next_illegal;
			EXIT_VIOLATION <= next_exit_violation;
			GATE_HOLD_VIOLATION <= next_hold_violation;
			STATE <= next_state;
		end
	end
endmodule
`default_nettype wire

// [bench/dcs_ctrl_model.sv]
`default_nettype none
module dcs_ctrl_model (
	// requests from the sequencer
	input wire logic clock,
	input wire logic [3:0] cmd_req,
	input wire logic gate_req,
	// pins toward the device
	output logic clock_gate,
	output logic chip_select_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {clock_gate, chip_select_n, ras_n, cas_n, we_n} = 5'h1F;
	// pins move on the falling edge only; sequencer sends listed codes and deselect 4'h8
	always @(negedge clock) begin
		chip_select_n <= cmd_req[3];
		// strobes are don't care when deselected: show the inverse, never the old value
		{ras_n, cas_n, we_n} <= cmd_req[3] ? ~{ras_n, cas_n, we_n} : cmd_req[2:0];
		clock_gate <= gate_req;
	end
endmodule
`default_nettype wire

// [bench/dcs_top_monitor.sv]
`default_nettype none
module dcs_top_monitor #(
	parameter int NONREAD_EXIT_CYCLES = 3,
	parameter int READ_EXIT_CYCLES = 5
) (
	// clock and pins
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic ENABLE,
	input wire logic CLOCK_GATE,
	input wire logic CHIP_SELECT_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic BEAT_VALID,
	input wire logic WRITE_BEAT_MASK,
	// results
	input wire logic [6:0] STATE,
	input wire logic ROW_ACTIVATE,
	input wire logic BURST_START,
	input wire logic TERMINATION_ACTIVE,
	input wire logic ILLEGAL_COMMAND,
	input wire logic EXIT_VIOLATION,
	input wire logic WRITE_STROBE,
	input wire logic [7:0] WRITE_DATA
);
	timeunit 1ns;
	timeprecision 1ps;
	logic gate_q;
	logic next_gate_q;
	// exit waits counted from the rule, not from the device counters
	int nr_wait;
	int next_nr_wait;
	int rd_wait;
	int next_rd_wait;
	wire logic [3:0] pins = {CHIP_SELECT_N, RAS_N, CAS_N, WE_N};
	wire logic quiet = CHIP_SELECT_N | (pins == dcs_pkg::CMD_NOP);
	wire logic hh = ENABLE & gate_q & CLOCK_GATE;
	wire logic fall = ENABLE & gate_q & ~CLOCK_GATE;
	wire logic s_idle = STATE == dcs_pkg::ST_IDLE;
	wire logic s_act = STATE == dcs_pkg::ST_ACTIVE;
	wire logic s_rd = STATE == dcs_pkg::ST_READ;
	wire logic s_sr = STATE == dcs_pkg::ST_SELF_REFRESH;
	wire logic s_low = s_sr | (STATE == dcs_pkg::ST_ACTIVE_PD) |
		(STATE == dcs_pkg::ST_PRECHARGE_PD);
	// previous gate sample, cleared by reset as in the device
	always_comb begin
		next_gate_q = ENABLE ? CLOCK_GATE : gate_q;
		next_nr_wait = nr_wait;
		next_rd_wait = rd_wait;
		if (ENABLE && s_sr && !gate_q && CLOCK_GATE && quiet) begin
			next_nr_wait = NONREAD_EXIT_CYCLES;
			next_rd_wait = READ_EXIT_CYCLES;
		end else if (ENABLE) begin
			next_nr_wait = (nr_wait > 0) ? nr_wait - 1 : 0;
			next_rd_wait = (rd_wait > 0) ? rd_wait - 1 : 0;
		end
	end
	always_ff @(posedge CLOCK) begin
		gate_q <= RESETN ? next_gate_q : 1'b0;
		nr_wait <= RESETN ? next_nr_wait : 0;
		rd_wait <= RESETN ? next_rd_wait : 0;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	a_idle_activate: assert property (
		hh && s_idle && pins == dcs_pkg::CMD_ACTIVATE |=> ROW_ACTIVATE && s_act)
		else $error("activate not taken");
	a_idle_read_refused: assert property (
		hh && s_idle && pins == dcs_pkg::CMD_READ |=> ILLEGAL_COMMAND && s_idle)
		else $error("idle read not refused");
	a_active_burst: assert property (
		hh && s_act && pins == dcs_pkg::CMD_READ |=> BURST_START && s_rd)
		else $error("read burst not started");
	a_read_wrong_dir: assert property (
		hh && s_rd && pins == dcs_pkg::CMD_WRITE |=> ILLEGAL_COMMAND && s_rd)
		else $error("write in read not refused");
	a_pd_entry: assert property (
		fall && quiet && s_act |=> STATE == dcs_pkg::ST_ACTIVE_PD)
		else $error("active power-down not entered");
	a_sr_entry: assert property (
		fall && s_idle && pins == dcs_pkg::CMD_REFRESH |=> s_sr)
		else $error("self refresh not entered");
	a_low_hold: assert property (
		ENABLE && !gate_q && !CLOCK_GATE && s_low |=> $stable(STATE) && !ILLEGAL_COMMAND)
		else $error("low-power state left");
	a_sr_exit: assert property (
		ENABLE && !gate_q && CLOCK_GATE && quiet && s_sr |=> s_idle)
		else $error("self refresh exit missed");
	a_sr_no_term: assert property (s_sr |-> !TERMINATION_ACTIVE)
		else $error("termination on in self refresh");
	a_mask_inhibit: assert property (
		ENABLE && BEAT_VALID && WRITE_BEAT_MASK |=> !WRITE_STROBE && $stable(WRITE_DATA))
		else $error("masked beat written");
	a_early_nonread: assert property (
		hh && nr_wait != 0 && !quiet |=> EXIT_VIOLATION)
		else $error("early command not flagged");
	a_early_read: assert property (
		hh && rd_wait != 0 && pins == dcs_pkg::CMD_READ |=> EXIT_VIOLATION)
		else $error("early read not flagged");
	c_sr_cycle: cover property (s_sr ##1 s_idle);
	c_pd_entry: cover property (s_act ##1 STATE == dcs_pkg::ST_ACTIVE_PD);
	c_write: cover property (WRITE_STROBE);
endmodule
bind dcs_top dcs_top_monitor #(
	.NONREAD_EXIT_CYCLES(NONREAD_EXIT_CYCLES),
	.READ_EXIT_CYCLES(READ_EXIT_CYCLES)
) dcs_top_monitor_inst (.CLOCK, .RESETN, .ENABLE, .CLOCK_GATE, .CHIP_SELECT_N, .RAS_N,
	.CAS_N, .WE_N, .BEAT_VALID, .WRITE_BEAT_MASK, .STATE, .ROW_ACTIVATE, .BURST_START,
	.TERMINATION_ACTIVE, .ILLEGAL_COMMAND, .EXIT_VIOLATION, .WRITE_STROBE, .WRITE_DATA);
`default_nettype wire

// [bench/dcs_top_tb_top.sv]
`default_nettype none
module dcs_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] cmd_req = dcs_pkg::CMD_NOP;
	logic gate_req = 1'b1;
	// {enable, termination, beat valid, mask, data}, applied at each falling edge
	logic [11:0] pend = 12'h800;
	logic enable = 1'b1;
	logic term = 1'b0;
	logic bvalid = 1'b0;
	logic bmask = 1'b0;
	logic [7:0] bdata = 8'h00;
	wire logic cg, csn, rasn, casn, wen;
	wire logic [6:0] state;
	wire logic row, rfs, mode, bst, bdone, tact, ill, xv, gv, ws;
	wire logic [7:0] wd;
	int n_mismatch = 0;
	int cmp_count = 0;
	initial forever #5 clock = ~clock;
	dcs_ctrl_model dcs_ctrl_model_inst (.clock(clock), .cmd_req(cmd_req), .gate_req(gate_req),
		.clock_gate(cg), .chip_select_n(csn), .ras_n(rasn), .cas_n(casn), .we_n(wen));
	// short exit waits keep the run brief
	dcs_top #(.NONREAD_EXIT_CYCLES(3), .READ_EXIT_CYCLES(5)) dcs_top_inst (.CLOCK(clock),
		.RESETN(resetn), .ENABLE(enable), .CLOCK_GATE(cg), .CHIP_SELECT_N(csn), .RAS_N(rasn),
		.CAS_N(casn), .WE_N(wen), .TERMINATION_ENABLE(term), .BEAT_VALID(bvalid),
		.WRITE_BEAT_MASK(bmask), .BEAT_DATA(bdata), .STATE(state), .ROW_ACTIVATE(row),
		.REFRESH_START(rfs), .MODE_ACCESS(mode), .BURST_START(bst), .BURST_DONE(bdone),
		.TERMINATION_ACTIVE(tact), .ILLEGAL_COMMAND(ill), .EXIT_VIOLATION(xv),
		.GATE_HOLD_VIOLATION(gv), .WRITE_STROBE(ws), .WRITE_DATA(wd));
	task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t value %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t flag %b exp %b", $time, got, exp);
		end
	endtask
	task automatic step(input logic [3:0] c, input logic g);
		cmd_req = c;
		gate_req = g;
		@(negedge clock);
		{enable, term, bvalid, bmask, bdata} = pend;
		@(posedge clock);
		#1;
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic rst();
		// low from time zero at start, so that call waits no extra edge
		if (resetn) begin
			@(negedge clock);
		end
		resetn = 1'b0;
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		repeat (3) step(dcs_pkg::CMD_NOP, 1'b1);
	endtask
	task automatic to_active();
		for (int i = 0; i < 4 && state !== 7'h02; i++) step(dcs_pkg::CMD_NOP, 1'b1);
		chk_v(state, 8'h02);
	endtask
	task automatic t_idle();
		chk_v(state, 8'h01);
		pend = 12'h000;
		step(dcs_pkg::CMD_ACTIVATE, 1'b1);
		chk_v(state, 8'h01);
		pend = 12'hC00;
		step(dcs_pkg::CMD_READ, 1'b1);
		chk_b(ill, 1'b1);
		chk_b(tact, 1'b1);
		step(dcs_pkg::CMD_REFRESH, 1'b1);
		chk_b(rfs, 1'b1);
		step(dcs_pkg::CMD_MODE_SET, 1'b1);
		chk_b(mode, 1'b1);
		step(dcs_pkg::CMD_PRECHARGE, 1'b1);
		chk_v(state, 8'h01);
		pend = 12'h800;
		step(dcs_pkg::CMD_ACTIVATE, 1'b1);
		chk_b(row, 1'b1);
		chk_v(state, 8'h02);
		$display("test idle done");
	endtask
	task automatic t_burst();
		step(dcs_pkg::CMD_READ, 1'b1);
		chk_b(bst, 1'b1);
		step(dcs_pkg::CMD_NOP, 1'b1);
		step(dcs_pkg::CMD_READ, 1'b1);
		chk_b(bst, 1'b1);
		step(dcs_pkg::CMD_WRITE, 1'b1);
		chk_b(ill, 1'b1);
		chk_v(state, 8'h04);
		to_active();
		chk_b(bdone, 1'b1);
		step(dcs_pkg::CMD_WRITE, 1'b1);
		chk_v(state, 8'h08);
		pend = 12'hAA5;
		step(dcs_pkg::CMD_NOP, 1'b1);
		chk_b(ws, 1'b1);
		pend = 12'hB3C;
		step(dcs_pkg::CMD_NOP, 1'b1);
		chk_b(ws, 1'b0);
		chk_v(wd, 8'hA5);
		pend = 12'h800;
		to_active();
		$display("test burst done");
	endtask
	task automatic t_pd();
		step(dcs_pkg::CMD_NOP, 1'b0);
		chk_v(state, 8'h20);
		repeat (3) step(dcs_pkg::CMD_ACTIVATE, 1'b0);
		chk_b(ill, 1'b0);
		chk_v(state, 8'h20);
		step(4'h8, 1'b1);
		chk_v(state, 8'h02);
		repeat (2) step(dcs_pkg::CMD_NOP, 1'b1);
		step(dcs_pkg::CMD_PRECHARGE, 1'b1);
		chk_v(state, 8'h01);
		repeat (2) step(dcs_pkg::CMD_NOP, 1'b1);
		step(dcs_pkg::CMD_NOP, 1'b0);
		chk_v(state, 8'h10);
		repeat (2) step(dcs_pkg::CMD_NOP, 1'b0);
		step(dcs_pkg::CMD_NOP, 1'b1);
		chk_v(state, 8'h01);
		repeat (2) step(dcs_pkg::CMD_NOP, 1'b1);
		$display("test power-down done");
	endtask
	task automatic t_sr();
		pend = 12'hC00;
		step(dcs_pkg::CMD_REFRESH, 1'b0);
		chk_v(state, 8'h40);
		chk_b(tact, 1'b0);
		repeat (2) step(dcs_pkg::CMD_WRITE, 1'b0);
		chk_v(state, 8'h40);
		step(dcs_pkg::CMD_NOP, 1'b1);
		chk_v(state, 8'h01);
		step(dcs_pkg::CMD_ACTIVATE, 1'b1);
		chk_b(xv, 1'b1);
		repeat (2) step(dcs_pkg::CMD_NOP, 1'b1);
		chk_b(xv, 1'b0);
		step(dcs_pkg::CMD_READ, 1'b1);
		chk_b(xv, 1'b1);
		pend = 12'h800;
		rst();
		step(dcs_pkg::CMD_NOP, 1'b0);
		step(dcs_pkg::CMD_NOP, 1'b1);
		chk_b(gv, 1'b1);
		chk_v(state, 8'h01);
		$display("test self refresh and hold done");
	endtask
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial begin
		rst();
		t_idle();
		t_burst();
		t_pd();
		t_sr();
		summarize();
	end
endmodule
`default_nettype wire
